// file: rtl/rsp_pins.sv
/*
 * Alarm interrupt pins, power-fail pin and serial slave port (SPI/3-wire).
 * Assumes alarm flags, enables and read data come from same-clock logic;
 * pins and the comparator level are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
module rsp_pins #(
	parameter int SQW_HALF = rsp_pkg::SQW_HALF_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire rsp_pkg::rsp_irq_cfg_t irq_cfg,
	input wire rsp_pkg::rsp_alarm_t alarm,
	input wire logic vcc_below_pf,
	input wire logic serial_protocol_select,
	input wire logic chip_enable,
	input wire logic serial_clock,
	input wire logic serial_in_pin,
	input wire logic [7:0] reg_rdata,
	output logic alarm_irq_out_a,
	output logic alarm_irq_oe_a,
	output logic alarm_irq_out_b,
	output logic alarm_irq_oe_b,
	output logic power_fail_out_n,
	output logic serial_out_pin,
	output logic serial_out_oe,
	output logic xfer_start,
	output rsp_pkg::rsp_reg_req_t reg_req
);
	// Clock registers live below the RAM window
	function automatic logic access_ok(input logic [6:0] a, input logic low);
		access_ok = !(low && (a < rsp_pkg::RAM_FIRST));
	endfunction : access_ok

	// Burst pointer wraps within its own window
	function automatic logic [6:0] next_addr(input logic [6:0] a);
		if (a == rsp_pkg::RTC_LAST) begin
			next_addr = rsp_pkg::RTC_FIRST;
		end else if (a == rsp_pkg::RAM_LAST) begin
			next_addr = rsp_pkg::RAM_FIRST;
		end else begin
			next_addr = a + 7'h01;
		end
	endfunction : next_addr

	// Synchronised inputs
	logic [rsp_pkg::SYNC_W-1:0] pin_raw;
	logic [rsp_pkg::SYNC_W-1:0] pin_s;
	logic ce_s;
	logic sclk_s;
	logic sdi_s;
	logic vlow_s;
	logic mode_3w;

	assign pin_raw[rsp_pkg::SY_CE] = chip_enable;
	assign pin_raw[rsp_pkg::SY_SCLK] = serial_clock;
	assign pin_raw[rsp_pkg::SY_SDI] = serial_in_pin;
	assign pin_raw[rsp_pkg::SY_MODE] = serial_protocol_select;
	assign pin_raw[rsp_pkg::SY_VLOW] = vcc_below_pf;

	rsp_sync #(
		.W(rsp_pkg::SYNC_W)
	) u_sync (
		.clock(clock),
		.srst(srst),
		.d(pin_raw),
		.q(pin_s)
	);

	assign ce_s = pin_s[rsp_pkg::SY_CE];
	assign sclk_s = pin_s[rsp_pkg::SY_SCLK];
	assign sdi_s = pin_s[rsp_pkg::SY_SDI];
	assign vlow_s = pin_s[rsp_pkg::SY_VLOW];
	// Strap is static, so a plain synchronised level is enough
	assign mode_3w = (pin_s[rsp_pkg::SY_MODE] == rsp_pkg::MODE_3WIRE);

	// Square wave for the second pin's alternate role
	logic sqw_level;

	rsp_sqw #(
		.HALF_CYC(SQW_HALF)
	) u_sqw (
		.clock(clock),
		.srst(srst),
		.enable(irq_cfg.b_is_sqw),
		.level(sqw_level)
	);

	// Pin group: interrupts and power fail
	logic irq_oe_a_reg;
	logic irq_oe_a_next;
	logic irq_oe_b_reg;
	logic irq_oe_b_next;
	logic pf_n_reg;
	logic pf_n_next;
	logic od_low_reg;

	always_comb begin
		// No supply gating here: alarms act on either supply
		irq_oe_a_next = (alarm.flag_a && irq_cfg.en_a) ||
			(irq_cfg.route_both && alarm.flag_b && irq_cfg.en_b);
		if (irq_cfg.b_is_sqw) begin
			irq_oe_b_next = !sqw_level;
		end else begin
			irq_oe_b_next = alarm.flag_b && irq_cfg.en_b;
		end
		pf_n_next = !vlow_s;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_oe_a_reg <= 1'b0;
			irq_oe_b_reg <= 1'b0;
			pf_n_reg <= rsp_pkg::PF_N_RST;
			od_low_reg <= 1'b0;
		end else begin
			irq_oe_a_reg <= irq_oe_a_next;
			irq_oe_b_reg <= irq_oe_b_next;
			pf_n_reg <= pf_n_next;
			od_low_reg <= 1'b0;
		end
	end

	// Open drain: data is always low, only the enable moves
	assign alarm_irq_out_a = od_low_reg;
	assign alarm_irq_out_b = od_low_reg;
	assign alarm_irq_oe_a = irq_oe_a_reg;
	assign alarm_irq_oe_b = irq_oe_b_reg;
	assign power_fail_out_n = pf_n_reg;

	// Serial group
	rsp_pkg::rsp_phase_t phase_reg;
	rsp_pkg::rsp_phase_t phase_next;
	logic sclk_d_reg;
	logic sclk_d_next;
	logic ce_d_reg;
	logic ce_d_next;
	logic [2:0] bit_reg;
	logic [2:0] bit_next;
	logic [7:0] rx_reg;
	logic [7:0] rx_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_next;
	logic [6:0] addr_reg;
	logic [6:0] addr_next;
	logic [7:0] wdata_reg;
	logic [7:0] wdata_next;
	logic wr_reg;
	logic wr_next;
	logic rd_reg;
	logic rd_next;
	logic [1:0] fetch_reg;
	logic [1:0] fetch_next;
	logic blk_reg;
	logic blk_next;
	logic dout_reg;
	logic dout_next;
	logic oe_reg;
	logic oe_next;
	logic start_reg;
	logic start_next;
	logic wstep_reg;
	logic wstep_next;
	logic rise;
	logic fall;
	logic [6:0] fetch_addr;

	// Edges of the host clock, found by the core clock
	assign rise = sclk_s && !sclk_d_reg;
	assign fall = !sclk_s && sclk_d_reg;

	always_comb begin
		phase_next = phase_reg;
		sclk_d_next = sclk_s;
		ce_d_next = ce_s;
		bit_next = bit_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		fetch_next = {fetch_reg[0], 1'b0};
		blk_next = blk_reg;
		dout_next = dout_reg;
		oe_next = oe_reg;
		start_next = ce_s && !ce_d_reg;
		fetch_addr = addr_reg;
		wstep_next = 1'b0;
		// Read data arrives one cycle after the read strobe
		if (fetch_reg[1]) begin
			tx_next = blk_reg ? rsp_pkg::BYTE_RST : reg_rdata;
		end
		// Late step keeps the write strobe paired with its own address
		if (wstep_reg) begin
			addr_next = next_addr(addr_reg);
		end
		if (!ce_s) begin
			// Dropping chip enable aborts the frame at once
			phase_next = rsp_pkg::PH_ADDR;
			bit_next = rsp_pkg::BIT_RST;
			oe_next = 1'b0;
			dout_next = rsp_pkg::DOUT_RST;
		end else begin
			if (rise) begin
				// 3-wire runs LSB first, SPI MSB first; one input pin either way
				if (mode_3w) begin
					rx_next = {sdi_s, rx_reg[7:1]};
				end else begin
					rx_next = {rx_reg[6:0], sdi_s};
				end
				bit_next = bit_reg + 3'h1;
				if (bit_reg == rsp_pkg::BIT_LAST) begin
					case (phase_reg)
						rsp_pkg::PH_ADDR: begin
							addr_next = rx_next[6:0];
							if (rx_next[rsp_pkg::RW_BIT] == rsp_pkg::RW_WRITE) begin
								phase_next = rsp_pkg::PH_WRITE;
							end else begin
								phase_next = rsp_pkg::PH_READ;
								fetch_addr = rx_next[6:0];
								rd_next = access_ok(fetch_addr, vlow_s);
								blk_next = !access_ok(fetch_addr, vlow_s);
								fetch_next[0] = 1'b1;
							end
						end
						rsp_pkg::PH_WRITE: begin
							wr_next = access_ok(addr_reg, vlow_s);
							wdata_next = rx_next;
							// Pointer steps on a cycle later, after the strobe
							wstep_next = 1'b1;
						end
						rsp_pkg::PH_READ: begin
							// Prefetch the next byte of a burst
							fetch_addr = next_addr(addr_reg);
							addr_next = fetch_addr;
							rd_next = access_ok(fetch_addr, vlow_s);
							blk_next = !access_ok(fetch_addr, vlow_s);
							fetch_next[0] = 1'b1;
						end
						default: begin
							phase_next = rsp_pkg::PH_ADDR;
						end
					endcase
				end
			end
			if (fall && (phase_reg == rsp_pkg::PH_READ)) begin
				// Output driven only while returning read data
				oe_next = 1'b1;
				if (mode_3w) begin
					dout_next = tx_reg[0];
					tx_next = {1'b0, tx_reg[7:1]};
				end else begin
					dout_next = tx_reg[7];
					tx_next = {tx_reg[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			phase_reg <= rsp_pkg::PH_ADDR;
			sclk_d_reg <= 1'b0;
			ce_d_reg <= 1'b0;
			bit_reg <= rsp_pkg::BIT_RST;
			rx_reg <= rsp_pkg::BYTE_RST;
			tx_reg <= rsp_pkg::BYTE_RST;
			addr_reg <= rsp_pkg::ADDR_RST;
			wdata_reg <= rsp_pkg::BYTE_RST;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			fetch_reg <= 2'h0;
			blk_reg <= 1'b0;
			dout_reg <= rsp_pkg::DOUT_RST;
			oe_reg <= 1'b0;
			start_reg <= 1'b0;
			wstep_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			sclk_d_reg <= sclk_d_next;
			ce_d_reg <= ce_d_next;
			bit_reg <= bit_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			fetch_reg <= fetch_next;
			blk_reg <= blk_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			start_reg <= start_next;
			wstep_reg <= wstep_next;
		end
	end

	// Limitation: host clock half period must span at least four core cycles
	assign serial_out_pin = dout_reg;
	assign serial_out_oe = oe_reg;
	assign xfer_start = start_reg;
	assign reg_req.wr = wr_reg;
	assign reg_req.rd = rd_reg;
	assign reg_req.addr = addr_reg;
	assign reg_req.wdata = wdata_reg;
endmodule : rsp_pins

// file: rtl/rsp_pkg.sv
/*
 * Shared constants and types for the alarm-interrupt and serial-pin block.
 * Assumes one 250 MHz core clock and a synchronous active-high reset.
 */
package rsp_pkg;
	// Core clock and derived counts
	localparam int CLK_PERIOD_NS = 4;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int SQW_HZ = 32768;
	// Half period of the square wave, rounded down to whole cycles
	localparam int SQW_HALF_CYC = CLK_HZ / (2 * SQW_HZ);
	localparam int SQW_CNT_W = 12;

	// Synchroniser bit positions
	localparam int SYNC_W = 5;
	localparam int SY_CE = 0;
	localparam int SY_SCLK = 1;
	localparam int SY_SDI = 2;
	localparam int SY_MODE = 3;
	localparam int SY_VLOW = 4;
	localparam logic [SYNC_W-1:0] SYNC_RST = 5'h00;

	// Address space and wrap points
	localparam int ADDR_W = 7;
	localparam logic [6:0] RTC_FIRST = 7'h00;
	localparam logic [6:0] RTC_LAST = 7'h1F;
	localparam logic [6:0] RAM_FIRST = 7'h20;
	localparam logic [6:0] RAM_LAST = 7'h7F;
	localparam logic [6:0] ADDR_RST = 7'h00;

	// Serial framing
	localparam int RW_BIT = 7;
	localparam logic RW_WRITE = 1'b1;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_RST = 3'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic MODE_3WIRE = 1'b0;

	// Output reset values
	localparam logic PF_N_RST = 1'b1;
	localparam logic DOUT_RST = 1'b1;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ = 2'b10
	} rsp_phase_t;

	typedef struct packed {
		logic route_both;
		logic b_is_sqw;
		logic en_a;
		logic en_b;
	} rsp_irq_cfg_t;

	typedef struct packed {
		logic flag_a;
		logic flag_b;
	} rsp_alarm_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rsp_reg_req_t;
endpackage : rsp_pkg

// file: rtl/rsp_sync.sv
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level or a clock far below the core rate.
 */
`timescale 1ns/10ps
module rsp_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	// First stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (srst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end
endmodule : rsp_sync

// file: rtl/rsp_sqw.sv
/*
 * Square-wave generator derived from the core clock by a divider.
 * Assumes the enable is a level from same-clock logic.
 */
`timescale 1ns/10ps
module rsp_sqw #(
	parameter int HALF_CYC = rsp_pkg::SQW_HALF_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic enable,
	output logic level
);
	localparam int CNT_W = rsp_pkg::SQW_CNT_W;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

	logic [rsp_pkg::SQW_CNT_W-1:0] cnt_reg;
	logic [rsp_pkg::SQW_CNT_W-1:0] cnt_next;
	logic level_reg;
	logic level_next;

	always_comb begin
		cnt_next = cnt_reg;
		level_next = level_reg;
		if (!enable) begin
			cnt_next = '0;
			level_next = 1'b1;
		end else if (cnt_reg == LAST) begin
			cnt_next = '0;
			level_next = ~level_reg;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_reg <= '0;
			level_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule : rsp_sqw

// file: tb/rsp_host.sv
/*
 * Host model: SPI or 3-wire master on the serial pins.
 * Assumes the bench clock; pins move 1 ns after its rising edge.
 */
`timescale 1ns/10ps
module rsp_host (
	input wire logic clock,
	input wire logic serial_protocol_select,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe,
	output logic chip_enable,
	output logic serial_clock,
	output logic serial_in_pin
);
	logic mosi = 1'b0;
	logic drv = 1'b1;
	int clash = 0;
	// Undriven shared line shows the inverse, never a stale bit
	wire line_lvl = serial_out_oe ? serial_out_pin : (drv ? mosi : !mosi);
	assign serial_in_pin = serial_protocol_select ? mosi : line_lvl;
	initial begin
		chip_enable = 1'b0;
		serial_clock = 1'b0;
	end
	always @(negedge clock) begin
		if (!serial_protocol_select && drv && serial_out_oe)
			clash++;
	end
	task automatic frame(input logic spi, input logic [23:0] tx, input int nb,
		input logic rd, output logic [23:0] rx);
		int p;
		rx = '0;
		@(posedge clock);
		#1 chip_enable = 1'b1;
		repeat (4) @(posedge clock);
		for (int i = 0; i < nb; i++) begin
			for (int j = 0; j < 8; j++) begin
				p = 16 - 8 * i + (spi ? 7 - j : j);
				#1 serial_clock = 1'b0;
				drv = !(rd && i > 0);
				mosi = tx[p];
				repeat (4) @(posedge clock);
				#1 rx[p] = line_lvl;
				serial_clock = 1'b1;
				repeat (4) @(posedge clock);
			end
		end
		#1 serial_clock = 1'b0;
		repeat (4) @(posedge clock);
		#1 chip_enable = 1'b0;
		repeat (8) @(posedge clock);
		#1 drv = 1'b1;
	endtask : frame
endmodule : rsp_host

// file: tb/rsp_pins_checker.sv
/*
 * Checker for rsp_pins: alarm, square-wave, power-fail and port relations.
 * Assumes one clock domain; attached by the bind below.
 */
`timescale 1ns/10ps
module rsp_pins_checker #(
	parameter int SQW_HALF = rsp_pkg::SQW_HALF_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire rsp_pkg::rsp_irq_cfg_t irq_cfg,
	input wire rsp_pkg::rsp_alarm_t alarm,
	input wire logic vcc_below_pf,
	input wire logic chip_enable,
	input wire logic alarm_irq_out_a,
	input wire logic alarm_irq_oe_a,
	input wire logic alarm_irq_out_b,
	input wire logic alarm_irq_oe_b,
	input wire logic power_fail_out_n,
	input wire logic serial_out_oe,
	input wire rsp_pkg::rsp_reg_req_t reg_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	int hi_reg;
	int hi_next;
	logic a_on;
	// Counter, since a run of 3814 cannot be unrolled
	always_comb hi_next = alarm_irq_oe_b ? hi_reg + 1 : 0;
	always_ff @(posedge clock) hi_reg <= srst ? 0 : hi_next;
	assign a_on = (alarm.flag_a && irq_cfg.en_a) ||
		(irq_cfg.route_both && alarm.flag_b && irq_cfg.en_b);
	sequence s_low_supply;
		vcc_below_pf [*6];
	endsequence
	sequence s_req;
		reg_req.wr || reg_req.rd;
	endsequence
	a_pin_a_cause: assert property (a_on |=> alarm_irq_oe_a)
		else $error("pin A not asserted");
	a_pin_a_free: assert property (!a_on |=> !alarm_irq_oe_a)
		else $error("pin A not released");
	a_pin_b_alarm: assert property (!irq_cfg.b_is_sqw |=>
		alarm_irq_oe_b == $past(alarm.flag_b && irq_cfg.en_b))
		else $error("pin B wrong");
	a_sqw_half: assert property ($fell(alarm_irq_oe_b) && irq_cfg.b_is_sqw &&
		$past(irq_cfg.b_is_sqw, SQW_HALF + 1) |-> hi_reg == SQW_HALF)
		else $error("square wave half period wrong");
	a_open_drain: assert property (!alarm_irq_out_a && !alarm_irq_out_b)
		else $error("pin driven high");
	a_pf_follow: assert property ((vcc_below_pf [*4] |-> !power_fail_out_n) and
		(!vcc_below_pf [*4] |-> power_fail_out_n))
		else $error("power fail pin wrong");
	a_block_clock: assert property (s_low_supply ##0 s_req |-> reg_req.addr >= 7'h20)
		else $error("clock register reached on low supply");
	a_req_pulse: assert property (s_req |=> !reg_req.wr && !reg_req.rd)
		else $error("request longer than one cycle");
	a_idle_quiet: assert property (!chip_enable [*5] |-> !serial_out_oe)
		else $error("data out driven while idle");
endmodule : rsp_pins_checker
bind rsp_pins rsp_pins_checker #(.SQW_HALF(SQW_HALF)) u_chk (.*);

// file: tb/testbench.sv
/*
 * Bench for rsp_pins: alarm pins, power-fail pin, SPI and 3-wire port.
 * Assumes rsp_host as the serial master on the same clock.
 */
`timescale 1ns/10ps
module testbench;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic vcc_below_pf = 1'b0;
	logic serial_protocol_select = 1'b0;
	rsp_pkg::rsp_irq_cfg_t irq_cfg = '0;
	rsp_pkg::rsp_alarm_t alarm = '0;
	logic [7:0] reg_rdata = 8'h00;
	logic chip_enable, serial_clock, serial_in_pin, serial_out_pin, serial_out_oe;
	logic alarm_irq_out_a, alarm_irq_oe_a, alarm_irq_out_b, alarm_irq_oe_b;
	logic power_fail_out_n, xfer_start;
	rsp_pkg::rsp_reg_req_t reg_req;
	logic [14:0] wq [$];
	logic [23:0] rx;
	int failures = 0;
	int compares = 0;
	int starts = 0;
	// Short half period keeps the run small
	rsp_pins #(.SQW_HALF(8)) dut (.*);
	rsp_host host (.*);
	initial begin
		forever #2 clock = ~clock;
	end
	function automatic logic [7:0] rd_val(input logic [6:0] a);
		return {1'b0, a} ^ 8'hA5;
	endfunction : rd_val
	// Look just after the edge so a strobe launched there is seen once
	always @(posedge clock) begin
		#1;
		if (reg_req.rd === 1'b1)
			reg_rdata <= rd_val(reg_req.addr);
		if (reg_req.wr === 1'b1)
			wq.push_back({reg_req.addr, reg_req.wdata});
		if (xfer_start === 1'b1)
			starts++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic complete_run;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_b(input logic v);
		int n;
		for (n = 0; n < 40 && alarm_irq_oe_b !== v; n++)
			tick(1);
		if (n == 40) begin
			failures++;
			complete_run();
		end
	endtask : wait_b
	task automatic t_irq;
		logic [5:0] v;
		for (int i = 0; i < 64; i++) begin
			v = i[5:0];
			irq_cfg = {v[5], 1'b0, v[4], v[3]};
			alarm = v[2:1];
			vcc_below_pf = v[0];
			tick(1);
			chk({alarm_irq_oe_a, alarm_irq_oe_b, alarm_irq_out_a, alarm_irq_out_b},
				{(v[2] & v[4]) | (v[5] & v[1] & v[3]), v[1] & v[3], 2'b00});
		end
		vcc_below_pf = 1'b0;
		$display("irq test done");
	endtask : t_irq
	task automatic t_sqw;
		int n;
		irq_cfg = 4'b0101;
		alarm = 2'b01;
		wait_b(1'b0);
		wait_b(1'b1);
		for (n = 0; n < 40 && alarm_irq_oe_b === 1'b1; n++)
			tick(1);
		chk(n[15:0], 16'h0008);
		irq_cfg = 4'b0000;
		$display("square wave test done");
	endtask : t_sqw
	task automatic t_pf;
		vcc_below_pf = 1'b1;
		tick(3);
		chk(power_fail_out_n, 16'h0000);
		vcc_below_pf = 1'b0;
		tick(3);
		chk(power_fail_out_n, 16'h0001);
		$display("power fail test done");
	endtask : t_pf
	task automatic t_ser(input logic spi);
		int s0;
		serial_protocol_select = spi;
		tick(4);
		wq.delete();
		s0 = starts;
		host.frame(spi, 24'h9F3C_C3, 3, 1'b0, rx);
		chk(16'(wq.size()), 16'h0002);
		if (wq.size() == 2) begin
			chk(wq[0], {1'b0, 7'h1F, 8'h3C});
			chk(wq[1], {1'b0, 7'h00, 8'hC3});
		end
		host.frame(spi, 24'h7F00_00, 3, 1'b1, rx);
		chk(rx[15:0], {rd_val(7'h7F), rd_val(7'h20)});
		chk(16'(starts - s0), 16'h0002);
		$display("serial test done");
	endtask : t_ser
	task automatic t_blk;
		vcc_below_pf = 1'b1;
		tick(4);
		wq.delete();
		host.frame(1'b1, 24'h8511_00, 2, 1'b0, rx);
		host.frame(1'b1, 24'hA522_00, 2, 1'b0, rx);
		chk(16'(wq.size()), 16'h0001);
		if (wq.size() == 1)
			chk(wq[0], {1'b0, 7'h25, 8'h22});
		host.frame(1'b1, 24'h0500_00, 2, 1'b1, rx);
		chk(rx[15:8], 16'h0000);
		vcc_below_pf = 1'b0;
		tick(4);
		$display("blocking test done");
	endtask : t_blk
	initial begin
		tick(4);
		srst = 1'b0;
		tick(4);
		t_irq();
		t_sqw();
		t_pf();
		t_ser(1'b0);
		t_ser(1'b1);
		t_blk();
		chk(16'(host.clash), 16'h0000);
		complete_run();
	end
endmodule : testbench
